// ==== bench/jtlm_lane_map_properties.sv ====
`timescale 1ns/1ps
// Checker on the framer ports
module jtlm_chk (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Samples and lanes
  input wire samp_valid,
  input wire samp_ready,
  input wire [255:0] link_a_lanes,
  input wire [255:0] link_b_lanes,
  input wire lanes_valid,
  input wire [7:0] link_a_lane_pwrdn,
  input wire [7:0] link_b_lane_pwrdn,
  input wire [3:0] lane_octets,
  input wire [7:0] link_a_did,
  input wire [7:0] link_b_did,
  input wire [23:0] lane_ids
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Sample set accepted
  sequence s_taken;
    samp_valid && samp_ready;
  endsequence
  // Registered outputs have had time to follow the settings
  sequence s_settled;
    aresetn [*3];
  endsequence
  a_frame_follows: assert property (s_taken |=> lanes_valid)
    else $error("frame missing after accepted samples");
  a_frame_cause: assert property (lanes_valid |-> $past(samp_valid && samp_ready))
    else $error("frame without accepted samples");
  a_lanes_hold: assert property (!(samp_valid && samp_ready) |=>
    $stable(link_a_lanes) && $stable(link_b_lanes))
    else $error("lanes changed between frames");
  a_did_plus_one: assert property (s_settled |-> link_b_did == link_a_did + 8'h01)
    else $error("link b identifier not link a plus one");
  a_lane_ids: assert property (lane_ids == 24'hfac688)
    else $error("lane identifiers wrong");
  a_pwrdn_match: assert property (s_settled |-> link_a_lane_pwrdn == link_b_lane_pwrdn)
    else $error("links power different lanes");
  a_wide_lanes: assert property (s_settled ##0 (lane_octets == 4'h4) |->
    link_a_lane_pwrdn == 8'hfe)
    else $error("four-octet mode not on one lane");
  a_tail_zero: assert property (lanes_valid && lane_octets == 4'h2 |->
    link_a_lanes[15:0] == 16'h0000 && link_b_lanes[15:0] == 16'h0000)
    else $error("tail bits not zero");
  a_octet_tail: assert property (lanes_valid && lane_octets == 4'h1 |->
    link_a_lanes[23:0] == 24'h000000 && link_b_lanes[23:0] == 24'h000000)
    else $error("one-octet lane tail not zero");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule // jtlm_chk
bind jtlm_lane_map jtlm_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .samp_valid(samp_valid), .samp_ready(samp_ready),
  .link_a_lanes(link_a_lanes), .link_b_lanes(link_b_lanes), .lanes_valid(lanes_valid),
  .link_a_lane_pwrdn(link_a_lane_pwrdn), .link_b_lane_pwrdn(link_b_lane_pwrdn),
  .lane_octets(lane_octets), .link_a_did(link_a_did), .link_b_did(link_b_did),
  .lane_ids(lane_ids));

// ==== bench/jtlm_rx_model.sv ====
`timescale 1ns/1ps
// Receiver side: takes every frame off the wires
module jtlm_rx_model (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Lanes from the framer
  input wire [255:0] link_a_lanes,
  input wire [255:0] link_b_lanes,
  input wire lanes_valid,
  input wire multiframe_start,
  // Last frame and counts
  output reg [255:0] rx_a,
  output reg [255:0] rx_b,
  output reg [7:0] rx_frames,
  output reg [7:0] rx_mf
);
  // Capture whole links so stray data on upper lanes is seen too
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_frames <= 8'h00;
      rx_mf <= 8'h00;
    end else if (lanes_valid) begin
      rx_a <= link_a_lanes;
      rx_b <= link_b_lanes;
      rx_frames <= rx_frames + 8'h01;
      rx_mf <= rx_mf + {7'h00, multiframe_start};
    end
  end
endmodule // jtlm_rx_model

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  reg aclk, aresetn, awv, wv, bry, arv, rry, sv;
  reg [7:0] awa, ara;
  reg [31:0] wd, rd;
  reg [1:0] rs;
  reg [95:0] sd;
  reg [15:0] cai, caq, cbi, cbq;
  reg [14:0] t0, t1;
  reg [11:0] s [0:7];
  reg [7:0] ml [0:7];
  reg [255:0] ea, eb;
  reg [7:0] ep, f0, m0;
  reg [3:0] eo;
  reg ok1, ok2, ok3;
  integer num_errors, checks_done, i, j;
  wire awr, wr_, bv, arr, rv, srdy, lv, mfs, fec;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [255:0] la, lb, rxa, rxb;
  wire [7:0] pa, pb, da, db, rxf, rxm;
  wire [3:0] oc;
  wire [23:0] ids;
  jtlm_lane_map dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .samp_data(sd), .chan_a_inphase(cai), .chan_a_quadrature(caq), .chan_b_inphase(cbi),
    .chan_b_quadrature(cbq), .samp_valid(sv), .samp_ready(srdy), .link_a_lanes(la),
    .link_b_lanes(lb), .lanes_valid(lv), .link_a_lane_pwrdn(pa), .link_b_lane_pwrdn(pb),
    .lane_octets(oc), .link_a_did(da), .link_b_did(db), .lane_ids(ids),
    .multiframe_start(mfs), .sync_hdr_fec(fec));
  jtlm_rx_model rx (.aclk(aclk), .aresetn(aresetn), .link_a_lanes(la), .link_b_lanes(lb),
    .lanes_valid(lv), .multiframe_start(mfs), .rx_a(rxa), .rx_b(rxb), .rx_frames(rxf),
    .rx_mf(rxm));
  // 125 MHz clock
  always #4 aclk = ~aclk;
  // Closing report
  task give_verdict;
    begin
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Compare, widened to the widest lane value
  task chk(input [255:0] g, input [255:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // Bounded wait ran out
  task hang;
    begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  endtask
  // Bus write; ready is looked at mid-cycle, acted on at the edge
  // Loop ends on the seen response, not on bready, whose update lags the edge
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
      ok3 = 1'b0;
      for (j = 0; j < 40 && !ok3; j = j + 1) begin
        @(negedge aclk);
        ok1 = (awr === 1'b1) && awv; ok2 = (wr_ === 1'b1) && wv; ok3 = (bv === 1'b1); rs = br;
        @(posedge aclk);
        if (ok1) awv <= 1'b0;
        if (ok2) wv <= 1'b0;
        if (ok3) bry <= 1'b0;
      end
      if (!ok3) hang;
      @(negedge aclk);
    end
  endtask
  // Bus read; data and response taken with rvalid
  task rdr(input [7:0] a);
    begin
      @(posedge aclk);
      ara <= a; arv <= 1'b1; rry <= 1'b1;
      ok3 = 1'b0;
      for (j = 0; j < 40 && !ok3; j = j + 1) begin
        @(negedge aclk);
        ok1 = (arr === 1'b1) && arv; ok3 = (rv === 1'b1); rd = rdat; rs = rr;
        @(posedge aclk);
        if (ok1) arv <= 1'b0;
        if (ok3) rry <= 1'b0;
      end
      if (!ok3) hang;
      @(negedge aclk);
    end
  endtask
  // Offer n sample sets back to back
  task frames(input integer n);
    integer c;
    begin
      c = 0;
      @(posedge aclk);
      sv <= 1'b1;
      for (j = 0; j < 40 && c < n; j = j + 1) begin
        @(negedge aclk);
        ok1 = srdy;
        @(posedge aclk);
        if (ok1) c = c + 1;
      end
      sv <= 1'b0;
      if (c < n) hang;
      repeat (2) @(negedge aclk);
    end
  endtask
  // Lane word of a decimated component: value with overrange in bit 0
  function [15:0] dw(input [15:0] v, input [14:0] t);
    dw = {v[15:1], (v[15] ? ~v[14:0] : v[14:0]) > t};
  endfunction
  // Expected links, power-down and octet count per mode
  task expect_mode(input [7:0] m);
    begin
      ea = {160'h0, s[4][3:0], s[6], 16'h0, s[2][7:0], s[4][11:4], 16'h0,
        s[0], s[2][11:8], 16'h0};
      eb = {160'h0, s[5][3:0], s[7], 16'h0, s[3][7:0], s[5][11:4], 16'h0,
        s[1], s[3][11:8], 16'h0};
      ep = 8'hf8; eo = 4'h2;
      case (m)
        8'h21: begin
          ea = {160'h0, s[2][3:0], s[3], 16'h0, s[1][7:0], s[2][11:4], 16'h0,
            s[0], s[1][11:8], 16'h0};
          eb = {160'h0, s[6][3:0], s[7], 16'h0, s[5][7:0], s[6][11:4], 16'h0,
            s[4], s[5][11:8], 16'h0};
        end
        8'h22: begin
          ea = {192'h0, s[2][11:4], 24'h0, s[0][11:4], 24'h0};
          eb = {192'h0, s[3][11:4], 24'h0, s[1][11:4], 24'h0};
          ep = 8'hfc; eo = 4'h1;
        end
        8'h23: begin
          ea = {192'h0, s[1][11:4], 24'h0, s[0][11:4], 24'h0};
          // Dual 8-bit takes channel B from slots 2 and 3
          eb = {192'h0, s[3][11:4], 24'h0, s[2][11:4], 24'h0};
          ep = 8'hfc; eo = 4'h1;
        end
        8'h25: begin
          ea = {192'h0, dw(caq, t1), 16'h0, dw(cai, t0), 16'h0};
          eb = {192'h0, dw(cbq, t1), 16'h0, dw(cbi, t0), 16'h0};
          ep = 8'hfc;
        end
        8'h26: begin
          ea = {224'h0, dw(cai, t0), 16'h0};
          eb = {224'h0, dw(caq, t1), 16'h0};
          ep = 8'hfe;
        end
        8'h27, 8'h38: begin
          ea = {224'h0, dw(cai, t0), dw(caq, t1)};
          eb = {224'h0, dw(cbi, t0), dw(cbq, t1)};
          ep = 8'hfe; eo = 4'h4;
        end
        default: ;
      endcase
    end
  endtask
  // Run one frame in mode m and compare what the receiver took
  task one_frame(input [7:0] m);
    begin
      frames(1);
      expect_mode(m);
      chk(rxa, ea);
      chk(rxb, eb);
      chk({pb, pa}, {ep, ep});
      chk(oc, eo);
    end
  endtask
  initial begin
    aclk = 0; aresetn = 0; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0; sv = 0;
    awa = 0; ara = 0; wd = 0; num_errors = 0; checks_done = 0;
    cai = 16'h1234; caq = 16'h2468; cbi = 16'h3690; cbq = 16'h0f0e;
    t0 = 15'h7fff; t1 = 15'h7fff;
    {ml[0], ml[1], ml[2], ml[3]} = 32'h20212223;
    {ml[4], ml[5], ml[6], ml[7]} = 32'h25262738;
    for (i = 0; i < 8; i = i + 1) begin
      s[i] = 12'h123 * (i[11:0] + 12'h001);
      sd[12*i +: 12] = s[i];
    end
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // Register reset values, then an unmapped place
    rdr(8'h00); chk(rd[9:0], 10'h020);
    rdr(8'h04); chk(rd[4:0], 5'h1f);
    rdr(8'h0c); chk({rd[30:16], rd[14:0]}, {15'h7fff, 15'h7fff});
    rdr(8'h14); chk({rs, rd}, {2'b10, 32'h0});
    chk(srdy, 1'b0);
    // Identifiers, including the wrap of link B
    wr(8'h08, 32'hff); chk({da, db}, 16'hff00);
    wr(8'h08, 32'h05); chk({da, db}, 16'h0506);
    chk(rs, 2'b00);
    chk(ids, 24'hfac688);
    // Write to an unmapped place is answered with an error
    wr(8'h14, 32'h0);
    chk(rs, 2'b10);
    // Every mode once, sync header mode toggled alongside
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h00, {22'h0, 1'b1, i[0], ml[i]});
      chk(fec, i[0]);
      one_frame(ml[i]);
    end
    // Overrange on one component at a time
    for (i = 0; i < 2; i = i + 1) begin
      t0 = i[0] ? 15'h7fff : 15'h0010;
      t1 = i[0] ? 15'h0010 : 15'h7fff;
      wr(8'h0c, {1'b0, t1, 1'b0, t0});
      wr(8'h00, {22'h0, 2'b10, 8'h27});
      one_frame(8'h27);
    end
    // Unlisted mode code refuses samples
    wr(8'h00, {22'h0, 2'b10, 8'h30});
    chk(srdy, 1'b0);
    // Multiframe of two frames over four back-to-back frames
    wr(8'h04, 32'h01);
    wr(8'h00, {22'h0, 2'b10, 8'h20});
    f0 = rxf; m0 = rxm;
    frames(4);
    chk(rxf - f0, 8'h04);
    chk(rxm - m0, 8'h02);
    give_verdict;
  end
endmodule // testbench

// ==== design/jtlm_lane_map.v ====
// Overview of operation
// - Single 12-bit six lanes: even samples on A
// - Single 12-bit six lanes: odd samples on B
// - Dual 12-bit six lanes: channel per link
// - Single 8-bit: A even, B odd samples
// - Dual 8-bit: channel A on A, B on B
// - Dual dec4: inphase lane0, quadrature lane1 per link
// - Single dec8: inphase A0, quadrature B0
// - Dual dec8: four octets, I then Q
// - Dual dec16: same four-octet layout
// - Sync header may carry CRC-12
// - No CRC-3 option is offered
// - Sync header may carry FEC instead
// - Software bit selects CRC-12 or FEC
// - One mode selector sets whole lane format
// - Multiframe length in frames is programmable
// - Sixteen lanes in two eight-lane links
// - Low lanes used, upper lanes powered down
// - Link A reports DID, link B DID+1
// - Lane id equals position within link
// - MSB first, tail bits zero
// - Dec lane word: 15-bit value plus overrange
// - Overrange flags from thresholds 0 and 1
`timescale 1ns/1ps
`include "jtlm_regs.vh"
module jtlm_lane_map (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Sample input, eight 12-bit samples per frame, sample n at [12n+11:12n]
  input wire [95:0] samp_data,
  // Complex input: chan A I, chan A Q, chan B I, chan B Q (16-bit signed)
  input wire [15:0] chan_a_inphase,
  input wire [15:0] chan_a_quadrature,
  input wire [15:0] chan_b_inphase,
  input wire [15:0] chan_b_quadrature,
  input wire samp_valid,
  output wire samp_ready,
  // Lane outputs, 32 bits per lane, octet 0 in the top byte
  output reg [255:0] link_a_lanes,
  output reg [255:0] link_b_lanes,
  output reg lanes_valid,
  output reg [7:0] link_a_lane_pwrdn,
  output reg [7:0] link_b_lane_pwrdn,
  output reg [3:0] lane_octets,
  // Identification and framing
  output reg [7:0] link_a_did,
  output reg [7:0] link_b_did,
  output wire [23:0] lane_ids,
  output reg multiframe_start,
  output reg sync_hdr_fec
);
  // Configuration registers
  reg [7:0] link_mode_select_ff;
  reg [4:0] multiframe_len_minus1_ff;
  reg [7:0] did_ff;
  reg [14:0] overrange_threshold0_ff;
  reg [14:0] overrange_threshold1_ff;
  reg shm_ff; // Sync header mode
  reg ena_ff; // Framer enable
  reg [4:0] frame_cnt_ff; // Frame within multiframe
  reg [31:0] frames_ff; // Frame counter for status
  // Bus state
  reg aw_hold_ff;
  reg [7:0] aw_addr_ff;
  reg w_hold_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  wire do_write;
  wire mode_ok;

  // Mode code check; unlisted codes stop the framer
  function legal_mode;
    input [7:0] m;
    begin
      case (m)
        `JTLM_MODE_S12_6L, `JTLM_MODE_D12_6L, `JTLM_MODE_S8_4L, `JTLM_MODE_D8_4L,
        `JTLM_MODE_DDEC4_4L, `JTLM_MODE_SDEC8_2L, `JTLM_MODE_DDEC8_2L,
        `JTLM_MODE_DDEC16_2L: legal_mode = 1'b1;
        default: legal_mode = 1'b0;
      endcase
    end
  endfunction

  // Active lanes per link for a mode
  function [3:0] lanes_of;
    input [7:0] m;
    begin
      case (m)
        `JTLM_MODE_S12_6L, `JTLM_MODE_D12_6L: lanes_of = 4'h3;
        `JTLM_MODE_S8_4L, `JTLM_MODE_D8_4L, `JTLM_MODE_DDEC4_4L: lanes_of = 4'h2;
        `JTLM_MODE_SDEC8_2L, `JTLM_MODE_DDEC8_2L, `JTLM_MODE_DDEC16_2L: lanes_of = 4'h1;
        default: lanes_of = 4'h0;
      endcase
    end
  endfunction

  // Octets per lane per frame for a mode
  function [3:0] octets_of;
    input [7:0] m;
    begin
      case (m)
        `JTLM_MODE_S12_6L, `JTLM_MODE_D12_6L: octets_of = 4'h2;
        `JTLM_MODE_S8_4L, `JTLM_MODE_D8_4L: octets_of = 4'h1;
        `JTLM_MODE_DDEC4_4L, `JTLM_MODE_SDEC8_2L: octets_of = 4'h2;
        `JTLM_MODE_DDEC8_2L, `JTLM_MODE_DDEC16_2L: octets_of = 4'h4;
        default: octets_of = 4'h0;
      endcase
    end
  endfunction

  // Sixteen-bit lane word: 15-bit value then overrange bit
  function [15:0] dword;
    input [15:0] v;
    input [14:0] t;
    reg [14:0] mag;
    begin
      mag = v[15] ? ~v[14:0] : v[14:0];
      dword = {v[15:1], (mag > t)};
    end
  endfunction

  assign mode_ok = legal_mode(link_mode_select_ff);
  // Lane identifiers are the position in the link, 3 bits each
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_lid
      wire [31:0] lid_w = gi; // Lane index as a plain vector
      assign lane_ids[3*gi +: 3] = lid_w[2:0];
    end
  endgenerate

  // Bus handshakes: one address and one data held, response after both
  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  // Framer takes one sample set per frame while running
  assign samp_ready = ena_ff & mode_ok;

  // Write channel and configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `JTLM_RESP_OKAY;
      link_mode_select_ff <= `JTLM_RST_MODE;
      shm_ff <= `JTLM_SHM_CRC12;
      ena_ff <= 1'b0;
      multiframe_len_minus1_ff <= `JTLM_RST_K;
      did_ff <= `JTLM_RST_DID;
      overrange_threshold0_ff <= `JTLM_RST_OT;
      overrange_threshold1_ff <= `JTLM_RST_OT;
    end else begin
      // Capture address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= `JTLM_RESP_OKAY;
        case (aw_addr_ff[7:2])
          // Mode selector, sync header mode, enable
          `JTLM_OFS_MODE >> 2: begin
            if (w_strb_ff[0]) link_mode_select_ff <= w_data_ff[`JTLM_MODE_LSB +: 8];
            if (w_strb_ff[1]) begin
              shm_ff <= w_data_ff[`JTLM_SHM_BIT];
              ena_ff <= w_data_ff[`JTLM_ENA_BIT];
            end
          end
          // Multiframe length minus one
          `JTLM_OFS_KCFG >> 2: begin
            if (w_strb_ff[0]) multiframe_len_minus1_ff <= w_data_ff[4:0];
          end
          `JTLM_OFS_DID >> 2: begin
            if (w_strb_ff[0]) did_ff <= w_data_ff[`JTLM_DID_LSB +: 8];
          end
          // Overrange thresholds
          `JTLM_OFS_OVRT >> 2: begin
            if (w_strb_ff[0]) overrange_threshold0_ff[7:0] <= w_data_ff[7:0];
            if (w_strb_ff[1]) overrange_threshold0_ff[14:8] <= w_data_ff[14:8];
            if (w_strb_ff[2]) overrange_threshold1_ff[7:0] <= w_data_ff[23:16];
            if (w_strb_ff[3]) overrange_threshold1_ff[14:8] <= w_data_ff[30:24];
          end
          `JTLM_OFS_STAT >> 2: bresp_ff <= `JTLM_RESP_OKAY; // Read-only, write ignored
          default: bresp_ff <= `JTLM_RESP_SLVERR; // Unmapped
        endcase
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `JTLM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= `JTLM_RESP_OKAY;
      case (s_axi_araddr[7:2])
        `JTLM_OFS_MODE >> 2: rdata_ff <= {22'h000000, ena_ff, shm_ff, link_mode_select_ff};
        `JTLM_OFS_KCFG >> 2: rdata_ff <= {27'h0000000, multiframe_len_minus1_ff};
        `JTLM_OFS_DID >> 2: rdata_ff <= {24'h000000, did_ff};
        `JTLM_OFS_OVRT >> 2:
          rdata_ff <= {1'b0, overrange_threshold1_ff, 1'b0, overrange_threshold0_ff};
        // Status: running, mode legal, frame index, frames sent
        `JTLM_OFS_STAT >> 2:
          rdata_ff <= {samp_ready, mode_ok, 1'b0, frame_cnt_ff, frames_ff[23:0]};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= `JTLM_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Lane packing for the selected mode, combinational
  reg [255:0] nxt_a;
  reg [255:0] nxt_b;
  reg [15:0] wai, waq, wbi, wbq;
  always @* begin
    nxt_a = 256'h0; // Unused lanes and tail bits stay zero
    nxt_b = 256'h0;
    wai = dword(chan_a_inphase, overrange_threshold0_ff);
    waq = dword(chan_a_quadrature, overrange_threshold1_ff);
    wbi = dword(chan_b_inphase, overrange_threshold0_ff);
    wbq = dword(chan_b_quadrature, overrange_threshold1_ff);
    case (link_mode_select_ff)
      // Even samples on A, odd on B, 12-bit MSB first
      `JTLM_MODE_S12_6L: begin
        nxt_a[31:16] = {samp_data[11:0], samp_data[35:32]};
        nxt_a[63:48] = {samp_data[31:24], samp_data[59:52]};
        nxt_a[95:80] = {samp_data[51:48], samp_data[83:72]};
        nxt_b[31:16] = {samp_data[23:12], samp_data[47:44]};
        nxt_b[63:48] = {samp_data[43:36], samp_data[71:64]};
        nxt_b[95:80] = {samp_data[63:60], samp_data[95:84]};
      end
      // Samples 0..3 are channel A, 4..7 channel B
      `JTLM_MODE_D12_6L: begin
        nxt_a[31:16] = {samp_data[11:0], samp_data[23:20]};
        nxt_a[63:48] = {samp_data[19:12], samp_data[35:28]};
        nxt_a[95:80] = {samp_data[27:24], samp_data[47:36]};
        nxt_b[31:16] = {samp_data[59:48], samp_data[71:68]};
        nxt_b[63:48] = {samp_data[67:60], samp_data[83:76]};
        nxt_b[95:80] = {samp_data[75:72], samp_data[95:84]};
      end
      // 8-bit: top byte of each 12-bit slot
      `JTLM_MODE_S8_4L: begin
        nxt_a[31:24] = samp_data[11:4];
        nxt_a[63:56] = samp_data[35:28];
        nxt_b[31:24] = samp_data[23:16];
        nxt_b[63:56] = samp_data[47:40];
      end
      // Dual 8-bit: A0,A1 then B0,B1 in slots 0..3
      `JTLM_MODE_D8_4L: begin
        nxt_a[31:24] = samp_data[11:4];
        nxt_a[63:56] = samp_data[23:16];
        nxt_b[31:24] = samp_data[35:28];
        nxt_b[63:56] = samp_data[47:40];
      end
      `JTLM_MODE_DDEC4_4L: begin
        nxt_a[31:16] = wai;
        nxt_a[63:48] = waq;
        nxt_b[31:16] = wbi;
        nxt_b[63:48] = wbq;
      end
      // Single channel uses the A complex inputs
      `JTLM_MODE_SDEC8_2L: begin
        nxt_a[31:16] = wai;
        nxt_b[31:16] = waq;
      end
      // Four octets: I word then Q word
      `JTLM_MODE_DDEC8_2L, `JTLM_MODE_DDEC16_2L: begin
        nxt_a[31:0] = {wai, waq};
        nxt_b[31:0] = {wbi, wbq};
      end
      default: begin
        nxt_a = 256'h0;
        nxt_b = 256'h0;
      end
    endcase
  end

  // Power-down masks: lanes at and above the count are off
  reg [7:0] nxt_pd;
  integer li;
  always @* begin
    nxt_pd = 8'hff;
    for (li = 0; li < 8; li = li + 1) begin
      if (li < lanes_of(link_mode_select_ff)) nxt_pd[li] = 1'b0;
    end
  end

  // Frame output and multiframe counting
  always @(posedge aclk) begin
    if (!aresetn) begin
      link_a_lanes <= 256'h0;
      link_b_lanes <= 256'h0;
      lanes_valid <= 1'b0;
      frame_cnt_ff <= 5'h00;
      frames_ff <= 32'h0000_0000;
      multiframe_start <= 1'b0;
    end else begin
      lanes_valid <= samp_valid & samp_ready;
      multiframe_start <= 1'b0;
      if (samp_valid && samp_ready) begin
        link_a_lanes <= nxt_a;
        link_b_lanes <= nxt_b;
        frames_ff <= frames_ff + 32'h0000_0001;
        multiframe_start <= (frame_cnt_ff == 5'h00);
        // Wrap after field value plus one frames
        if (frame_cnt_ff >= multiframe_len_minus1_ff) frame_cnt_ff <= 5'h00;
        else frame_cnt_ff <= frame_cnt_ff + 5'h01;
      end else if (!samp_ready) begin
        frame_cnt_ff <= 5'h00;
      end
    end
  end

  // Static per-link outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      link_a_lane_pwrdn <= 8'hff;
      link_b_lane_pwrdn <= 8'hff;
      lane_octets <= 4'h0;
      link_a_did <= `JTLM_RST_DID;
      link_b_did <= `JTLM_RST_DID;
      sync_hdr_fec <= `JTLM_SHM_CRC12;
    end else begin
      link_a_lane_pwrdn <= nxt_pd; // Both links same count
      link_b_lane_pwrdn <= nxt_pd;
      lane_octets <= octets_of(link_mode_select_ff);
      link_a_did <= did_ff;
      link_b_did <= did_ff + 8'h01;
      // Only CRC-12 or FEC; no CRC-3 code exists
      sync_hdr_fec <= shm_ff;
    end
  end
endmodule // jtlm_lane_map

// ==== design/jtlm_regs.vh ====
`ifndef JTLM_REGS_VH
`define JTLM_REGS_VH
// Register byte offsets
`define JTLM_OFS_MODE 8'h00
`define JTLM_OFS_KCFG 8'h04
`define JTLM_OFS_DID 8'h08
`define JTLM_OFS_OVRT 8'h0c
`define JTLM_OFS_STAT 8'h10
// Link mode selector codes
`define JTLM_MODE_S12_6L 8'h20
`define JTLM_MODE_D12_6L 8'h21
`define JTLM_MODE_S8_4L 8'h22
`define JTLM_MODE_D8_4L 8'h23
`define JTLM_MODE_DDEC4_4L 8'h25
`define JTLM_MODE_SDEC8_2L 8'h26
`define JTLM_MODE_DDEC8_2L 8'h27
`define JTLM_MODE_DDEC16_2L 8'h38
// Field positions
`define JTLM_MODE_LSB 0
`define JTLM_SHM_BIT 8
`define JTLM_ENA_BIT 9
`define JTLM_DID_LSB 0
`define JTLM_OT0_LSB 0
`define JTLM_OT1_LSB 16
// Reset values
`define JTLM_RST_MODE 8'h20
`define JTLM_RST_K 5'h1f
`define JTLM_RST_DID 8'h00
`define JTLM_RST_OT 15'h7fff
// Sync header modes
`define JTLM_SHM_CRC12 1'b0
`define JTLM_SHM_FEC 1'b1
// Bus responses
`define JTLM_RESP_OKAY 2'b00
`define JTLM_RESP_SLVERR 2'b10
`endif
